// >>> hscs_checker.sv
`timescale 1ns/1ps
// ==========================================================
// Port checker for the heatseal sequencer
// ==========================================================
module hscs_checker
  import hscs_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RESET_N_I,
  input wire logic HEAT_REQUEST_I,
  input wire logic MANUAL_HEAT_KEY_I,
  input wire logic TIME_CONTROL_I,
  input wire logic OUT_REF_MODE_I,
  input wire logic [1:0] RANGE_I,
  input wire logic [TEMP_W-1:0] MAX_TEMP_I,
  input wire logic FAULT_ACTIVE_I,
  input wire logic [CODE_W-1:0] FAULT_CODE_I,
  input wire logic [DAC_W-1:0] FAULT_LEVEL_I,
  input wire logic HEAT_ENABLE_O,
  input wire logic TIMED_CYCLE_START_O,
  input wire logic [TEMP_W-1:0] SET_POINT_O,
  input wire logic ALARM_O,
  input wire logic [DAC_W-1:0] ANALOG_LEVEL_O,
  input wire logic CAL_BUSY_O,
  input wire logic [3:0] CAL_COUNT_O
);
  // Range ceiling worked out here, independent of the design
  logic [TEMP_W-1:0] ceil_c;
  // High for the fault codes that turn a heat request into an alarm
  logic alarm_code;
  assign ceil_c = (RANGE_I == RANGE_200) ? CEIL_200 : (RANGE_I == RANGE_300) ? CEIL_300 :
    (RANGE_I == RANGE_400) ? CEIL_400 : CEIL_500;
  assign alarm_code = FAULT_CODE_I inside {[10'h068:10'h069], [10'h06F:10'h071], 10'h0D3};

  // ==========================================================
  // Sequences
  // ==========================================================
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RESET_N_I);
  // Four cycles cover the two-stage synchroniser plus the output flop
  sequence req_held;
    (HEAT_REQUEST_I && !TIME_CONTROL_I && !FAULT_ACTIVE_I && !CAL_BUSY_O &&
     SET_POINT_O > MIN_HEAT_SET_C)[*4];
  endsequence
  sequence req_gone;
    (!HEAT_REQUEST_I && !MANUAL_HEAT_KEY_I && !TIME_CONTROL_I)[*4];
  endsequence
  sequence alarm_req;
    (HEAT_REQUEST_I && FAULT_ACTIVE_I && alarm_code && !MANUAL_HEAT_KEY_I)[*4];
  endsequence

  // ==========================================================
  // Assertions
  // ==========================================================
  a_low_set: assert property (SET_POINT_O <= MIN_HEAT_SET_C &&
    $past(SET_POINT_O) <= MIN_HEAT_SET_C |-> !HEAT_ENABLE_O) else $error("heat at low set point");
  a_set_cap: assert property (SET_POINT_O <= $past(MAX_TEMP_I) &&
    SET_POINT_O <= $past(ceil_c)) else $error("set point above cap");
  a_untimed_heat: assert property (req_held |-> HEAT_ENABLE_O)
    else $error("held request not heating");
  a_heat_release: assert property (req_gone |-> !HEAT_ENABLE_O)
    else $error("heating after release");
  a_alarm_code: assert property (alarm_req |-> ALARM_O && !HEAT_ENABLE_O)
    else $error("alarm fault did not block heat");
  a_fault_level: assert property ((FAULT_ACTIVE_I && !CAL_BUSY_O)[*2] |->
    ANALOG_LEVEL_O == $past(FAULT_LEVEL_I)) else $error("fault level not shown");
  a_ref_out: assert property ((OUT_REF_MODE_I && !FAULT_ACTIVE_I && !CAL_BUSY_O)[*2] |->
    ANALOG_LEVEL_O == DAC_FULL) else $error("reference level wrong");
  a_cal_zero: assert property (CAL_BUSY_O[*2] |-> ANALOG_LEVEL_O == DAC_ZERO &&
    !HEAT_ENABLE_O) else $error("output or heat during calibration");
  a_cal_count: assert property ($rose(CAL_BUSY_O) |-> (CAL_COUNT_O == CAL_COUNT_START)[*8])
    else $error("countdown not starting at 13");
  a_heat_lock: assert property ((HEAT_REQUEST_I && !CAL_BUSY_O)[*4] |=> !CAL_BUSY_O)
    else $error("calibration started under heat request");
  a_timed_edge: assert property (TIMED_CYCLE_START_O |->
    $past(HEAT_REQUEST_I, 3) && !$past(HEAT_REQUEST_I, 4)) else $error("cycle start off edge");
endmodule

bind hscs_top hscs_checker CHK (.CLK_I, .RESET_N_I, .HEAT_REQUEST_I, .MANUAL_HEAT_KEY_I,
  .TIME_CONTROL_I, .OUT_REF_MODE_I, .RANGE_I, .MAX_TEMP_I, .FAULT_ACTIVE_I, .FAULT_CODE_I,
  .FAULT_LEVEL_I, .HEAT_ENABLE_O, .TIMED_CYCLE_START_O, .SET_POINT_O, .ALARM_O,
  .ANALOG_LEVEL_O, .CAL_BUSY_O, .CAL_COUNT_O);

// >>> hscs_fault.sv
`timescale 1ns/1ps
// ============================================================
// Fault code classifier
// ============================================================
module hscs_fault
  import hscs_pkg::*;
(
  input wire logic [CODE_W-1:0] code_i,
  input wire logic ran_ok_i,
  output logic cal_block_o,
  output logic heat_alarm_o
);
  // Helper: code inside an inclusive decimal span
  function automatic logic in_span(input logic [CODE_W-1:0] c, input int lo, input int hi);
    in_span = (int'(c) >= lo) && (int'(c) <= hi);
  endfunction
  // Group membership, codes are decimal values
  wire logic grp_1xx = in_span(code_i, 101, 103);
  wire logic grp_2xx = in_span(code_i, 201, 203);
  wire logic grp_801 = in_span(code_i, 801, 801);
  wire logic grp_9xx = in_span(code_i, 900, 999);
  assign cal_block_o = grp_2xx || grp_801 || grp_9xx || (grp_1xx && !ran_ok_i);
  // codes that refuse a heat request
  assign heat_alarm_o = in_span(code_i, 104, 105) || in_span(code_i, 111, 113) ||
    in_span(code_i, 211, 211);
endmodule

// >>> hscs_machine.sv
`timescale 1ns/1ps
// ==========================================================
// Machine control model: heat and warmup request pins
// ==========================================================
module hscs_machine (
  input wire logic clk_i,
  output logic heat_o,
  output logic warm_o
);
  // Both requests idle low from time zero
  initial begin
    heat_o = 1'h0;
    warm_o = 1'h0;
  end
  // Pins change only off the sampling edge
  task heat(input logic v);
    @(negedge clk_i);
    heat_o = v;
  endtask
  task warm(input logic v);
    @(negedge clk_i);
    warm_o = v;
  endtask
  task cycle(input int n);
    heat(1'h1);
    repeat (n) @(negedge clk_i);
    heat(1'h0);
    // Low long enough to pass the synchroniser before any new request
    repeat (6) @(negedge clk_i);
  endtask
endmodule

// >>> hscs_pkg.sv
// Behaviour
// - No heating unless set point exceeds 40 C
// - Cap set point at maximum or range ceiling
// - Analog output linear, 0 V at 0 C
// - Full scale 300 C or 500 C by range
// - Active fault drives fault level on output
// - Select actual temperature or fixed 10 V
// - Confirm key starts calibration; ambient 0 to 40
// - Calibration reference defaults to 20 C
// - Calibration about 13 s, heating inhibited
// - Countdown 13 to 0, output forced near 0 V
// - Up to three attempts, then error
// - Refuse calibration while band cools fast
// - Refuse calibration while heat or warmup active
// - Power-up and later calibration blocking fault sets
// - Untimed heat request heats while asserted
// - Manual heat key heats at once, no timeout
// - Timed mode: each request starts one cycle
// - Home position shows value and bar
// - Heat request ignored during calibration
// - Heat request during listed faults sets alarm
package hscs_pkg;

  // ==========================================================
  // Temperature and output scaling
  // ==========================================================
  localparam int TEMP_W = 10;
  localparam int DAC_W = 12;
  localparam logic [TEMP_W-1:0] MIN_HEAT_SET_C = 10'h028;
  localparam logic [TEMP_W-1:0] CAL_REF_DEFAULT_C = 10'h014;
  localparam logic [TEMP_W-1:0] CAL_AMB_MAX_C = 10'h028;
  localparam logic [TEMP_W-1:0] FS_LOW_C = 10'h12C;
  localparam logic [TEMP_W-1:0] FS_HIGH_C = 10'h1F4;
  localparam logic [DAC_W-1:0] DAC_FULL = 12'hFFF;
  localparam logic [DAC_W-1:0] DAC_ZERO = 12'h000;
  // Range codes: 0=200, 1=300, 2=400, 3=500
  localparam logic [1:0] RANGE_200 = 2'h0;
  localparam logic [1:0] RANGE_300 = 2'h1;
  localparam logic [1:0] RANGE_400 = 2'h2;
  localparam logic [1:0] RANGE_500 = 2'h3;
  // Range ceilings in degrees
  localparam logic [TEMP_W-1:0] CEIL_200 = 10'h0C8;
  localparam logic [TEMP_W-1:0] CEIL_300 = 10'h12C;
  localparam logic [TEMP_W-1:0] CEIL_400 = 10'h190;
  localparam logic [TEMP_W-1:0] CEIL_500 = 10'h1F4;

  // ==========================================================
  // Fault codes (three-digit decimal numbers as plain binary)
  // ==========================================================
  localparam int CODE_W = 10;
  localparam logic [CODE_W-1:0] ERR_CAL_FAIL = 10'h09B; // 155, calibration failed

  // ==========================================================
  // Calibration timing
  // ==========================================================
  localparam int CLK_HZ = 25000000;
  localparam int CAL_TICK_MS = 1000;
  localparam int CAL_TICK_CYC = CLK_HZ / 1000 * CAL_TICK_MS;
  localparam logic [3:0] CAL_COUNT_START = 4'hD;
  localparam logic [1:0] CAL_MAX_TRIES = 2'h3;

endpackage

// >>> hscs_scale.sv
`timescale 1ns/1ps
// ============================================================
// Temperature to output-level scaler
// ============================================================
module hscs_scale
  import hscs_pkg::*;
(
  input wire logic [TEMP_W-1:0] temp_i,
  input wire logic [1:0] range_i,
  output logic [DAC_W-1:0] level_o
);
  // Full scale is 300 for the two low ranges, 500 for the high
  // full scale choice
  wire logic [TEMP_W-1:0] full_scale = range_i[1] ? FS_HIGH_C : FS_LOW_C;
  // Clip above full scale so the meter never wraps
  wire logic [TEMP_W-1:0] temp_clip = (temp_i > full_scale) ? full_scale : temp_i;
  wire logic [21:0] product = 22'(temp_clip) * 22'(DAC_FULL);
  wire logic [21:0] quotient = product / 22'(full_scale);
  assign level_o = quotient[DAC_W-1:0];
endmodule

// >>> hscs_top.sv
`timescale 1ns/1ps
// ============================================================
// Heatseal control sequencer
// ============================================================
module hscs_top
  import hscs_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RESET_N_I,
  input wire logic CE_I,
  // Machine-control pins, asynchronous
  input wire logic HEAT_REQUEST_I,
  input wire logic WARMUP_REQUEST_I,
  // Front panel keys, already debounced, on this clock
  input wire logic MANUAL_HEAT_KEY_I,
  input wire logic HOME_POSITION_I,
  input wire logic CAL_STEP_SELECTED_I,
  input wire logic CONFIRM_KEY_I,
  input wire logic UP_KEY_I,
  input wire logic DOWN_KEY_I,
  // Configuration
  input wire logic TIME_CONTROL_I,
  input wire logic OUT_REF_MODE_I,
  input wire logic [1:0] RANGE_I,
  input wire logic [TEMP_W-1:0] MAX_TEMP_I,
  input wire logic [TEMP_W-1:0] SET_POINT_I,
  // Measurement and fault state from the control loop
  input wire logic [TEMP_W-1:0] ACTUAL_TEMP_I,
  input wire logic COOLING_FAST_I,
  input wire logic BAND_VARIES_I,
  input wire logic FAULT_ACTIVE_I,
  input wire logic [CODE_W-1:0] FAULT_CODE_I,
  input wire logic [DAC_W-1:0] FAULT_LEVEL_I,
  input wire logic RAN_OK_I,
  input wire logic TIMED_CYCLE_DONE_I,
  // Outputs
  output logic HEAT_ENABLE_O,
  output logic TIMED_CYCLE_START_O,
  output logic [TEMP_W-1:0] SET_POINT_O,
  output logic ALARM_O,
  output logic [DAC_W-1:0] ANALOG_LEVEL_O,
  output logic CAL_BUSY_O,
  output logic [3:0] CAL_COUNT_O,
  output logic CAL_ERROR_O,
  output logic [TEMP_W-1:0] CAL_REF_O,
  output logic MSG_STILL_HOT_O,
  output logic MSG_LOCK_HEAT_O,
  output logic MSG_LOCK_WARMUP_O,
  output logic SHOW_VALUE_O,
  output logic SHOW_BAR_O
);

  // ==========================================================
  // Types and state
  // ==========================================================
  typedef enum logic [2:0] {
    CAL_IDLE = 3'h1,
    CAL_RUN = 3'h2,
    CAL_CHECK = 3'h4
  } hscs_cal_t;

  hscs_cal_t cal_state_reg; // Calibration sequencer state
  hscs_cal_t cal_state_next;
  logic heat_s1_reg; // Heat request synchroniser, first stage
  logic heat_s2_reg; // Heat request, synchronised
  logic warm_s1_reg; // Warmup request synchroniser, first stage
  logic warm_s2_reg; // Warmup request, synchronised
  logic heat_prev_reg; // Last heat level, edge detect
  logic armed_reg; // New timed cycle may start
  logic timed_active_reg; // Timed cycle under way
  logic [24:0] tick_cnt_reg; // One-second prescaler
  logic [3:0] count_reg; // Countdown shown on display
  logic [1:0] tries_reg; // Attempts used so far
  logic band_moved_reg; // Band moved during this attempt
  logic cal_err_reg; // Calibration failed three times
  logic [TEMP_W-1:0] cal_ref_reg; // Assumed ambient
  logic confirm_prev_reg; // Confirm key edge detect
  logic up_prev_reg;
  logic down_prev_reg;
  logic [TEMP_W-1:0] set_cap_reg;
  logic heat_en_reg;
  logic start_pulse_reg;
  logic alarm_reg;
  logic [DAC_W-1:0] level_reg;
  logic hot_reg;
  logic lock_h_reg;
  logic lock_w_reg;
  logic show_reg;
  logic busy_reg; // Registered copy of the busy state for the pin

  // ==========================================================
  // Combinational decode
  // ==========================================================
  wire logic cal_block;
  wire logic heat_alarm_code;
  wire logic [DAC_W-1:0] scaled_level;
  hscs_fault u_fault (
    .code_i(FAULT_CODE_I),
    .ran_ok_i(RAN_OK_I),
    .cal_block_o(cal_block),
    .heat_alarm_o(heat_alarm_code)
  );
  hscs_scale u_scale (
    .temp_i(ACTUAL_TEMP_I),
    .range_i(RANGE_I),
    .level_o(scaled_level)
  );

  wire logic [TEMP_W-1:0] range_ceil = (RANGE_I == RANGE_200) ? CEIL_200 :
    (RANGE_I == RANGE_300) ? CEIL_300 : (RANGE_I == RANGE_400) ? CEIL_400 : CEIL_500;
  wire logic [TEMP_W-1:0] ceil_min = (MAX_TEMP_I < range_ceil) ? MAX_TEMP_I : range_ceil;
  wire logic [TEMP_W-1:0] set_cap = (SET_POINT_I > ceil_min) ? ceil_min : SET_POINT_I;

  wire logic cal_busy = (cal_state_reg != CAL_IDLE);
  wire logic heat_seen = heat_s2_reg && !cal_busy;
  // manual key only in home position
  wire logic manual_seen = MANUAL_HEAT_KEY_I && HOME_POSITION_I && !cal_busy;
  wire logic set_ok = (set_cap > MIN_HEAT_SET_C);
  wire logic fault_refuse = heat_alarm_code && FAULT_ACTIVE_I;
  wire logic heat_rise = heat_seen && !heat_prev_reg && armed_reg;
  wire logic untimed_heat = !TIME_CONTROL_I && heat_seen;
  // timed cycle heats until loop ends it
  wire logic timed_heat = TIME_CONTROL_I && timed_active_reg;
  wire logic heat_next = (untimed_heat || timed_heat || manual_seen) && set_ok &&
    !fault_refuse && !cal_busy;
  wire logic alarm_next = (heat_seen || manual_seen) && fault_refuse;

  // Calibration start conditions
  wire logic confirm_rise = CONFIRM_KEY_I && !confirm_prev_reg;
  wire logic still_hot = CAL_STEP_SELECTED_I && COOLING_FAST_I;
  wire logic lock_h = CAL_STEP_SELECTED_I && heat_s2_reg;
  wire logic lock_w = CAL_STEP_SELECTED_I && warm_s2_reg;
  // start on confirm at calibration step
  wire logic cal_go = CAL_STEP_SELECTED_I && confirm_rise && !COOLING_FAST_I &&
    !heat_s2_reg && !warm_s2_reg && !cal_block;
  wire logic tick = (tick_cnt_reg == 25'(CAL_TICK_CYC - 1));
  wire logic count_zero = (count_reg == 4'h0);

  wire logic [DAC_W-1:0] level_next = cal_busy ? DAC_ZERO :
    FAULT_ACTIVE_I ? FAULT_LEVEL_I : OUT_REF_MODE_I ? DAC_FULL : scaled_level;

  // ==========================================================
  // Calibration state transitions
  // ==========================================================
  always_comb begin
    cal_state_next = cal_state_reg;
    unique case (cal_state_reg)
      CAL_IDLE: begin
        if (cal_go) begin
          cal_state_next = CAL_RUN;
        end
      end
      CAL_RUN: begin
        if (tick && count_zero) begin
          cal_state_next = CAL_CHECK;
        end
      end
      CAL_CHECK: begin
        if (band_moved_reg && (tries_reg < CAL_MAX_TRIES)) begin
          cal_state_next = CAL_RUN;
        end else begin
          cal_state_next = CAL_IDLE;
        end
      end
      default: begin
        cal_state_next = CAL_IDLE;
      end
    endcase
  end

  // ==========================================================
  // Input synchronisers
  // ==========================================================
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      heat_s1_reg <= 1'b0;
      heat_s2_reg <= 1'b0;
      warm_s1_reg <= 1'b0;
      warm_s2_reg <= 1'b0;
    end else if (CE_I) begin
      heat_s1_reg <= HEAT_REQUEST_I;
      heat_s2_reg <= heat_s1_reg;
      warm_s1_reg <= WARMUP_REQUEST_I;
      warm_s2_reg <= warm_s1_reg;
    end
  end

  // ==========================================================
  // Heat request sequencing
  // ==========================================================
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      heat_prev_reg <= 1'b0;
      armed_reg <= 1'b1;
      timed_active_reg <= 1'b0;
      start_pulse_reg <= 1'b0;
    end else if (CE_I) begin
      heat_prev_reg <= heat_seen;
      start_pulse_reg <= 1'b0;
      if (!heat_s2_reg) begin
        armed_reg <= 1'b1;
      end else if (heat_rise) begin
        armed_reg <= 1'b0;
      end
      // start one timed cycle per request
      if (TIME_CONTROL_I && heat_rise && set_ok && !fault_refuse) begin
        timed_active_reg <= 1'b1;
        start_pulse_reg <= 1'b1;
      end else if (TIMED_CYCLE_DONE_I || !TIME_CONTROL_I || cal_busy) begin
        timed_active_reg <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Calibration sequencer registers
  // ==========================================================
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      cal_state_reg <= CAL_IDLE;
      tick_cnt_reg <= 25'h0000000;
      count_reg <= 4'h0;
      tries_reg <= 2'h0;
      band_moved_reg <= 1'b0;
      cal_err_reg <= 1'b0;
      confirm_prev_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else if (CE_I) begin
      cal_state_reg <= cal_state_next;
      busy_reg <= (cal_state_next != CAL_IDLE);
      confirm_prev_reg <= CONFIRM_KEY_I;
      if (cal_state_reg == CAL_RUN) begin
        tick_cnt_reg <= tick ? 25'h0000000 : tick_cnt_reg + 25'h0000001;
        if (tick && !count_zero) begin
          count_reg <= count_reg - 4'h1;
        end
        if (BAND_VARIES_I) begin
          band_moved_reg <= 1'b1;
        end
      end else begin
        tick_cnt_reg <= 25'h0000000;
        count_reg <= CAL_COUNT_START;
      end
      if (cal_go) begin
        tries_reg <= 2'h1;
        band_moved_reg <= 1'b0;
        cal_err_reg <= 1'b0;
      end else if (cal_state_reg == CAL_CHECK) begin
        band_moved_reg <= 1'b0;
        if (band_moved_reg && (tries_reg < CAL_MAX_TRIES)) begin
          tries_reg <= tries_reg + 2'h1;
        end else if (band_moved_reg) begin
          cal_err_reg <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // Ambient reference adjustment
  // ==========================================================
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      cal_ref_reg <= CAL_REF_DEFAULT_C;
      up_prev_reg <= 1'b0;
      down_prev_reg <= 1'b0;
    end else if (CE_I) begin
      up_prev_reg <= UP_KEY_I;
      down_prev_reg <= DOWN_KEY_I;
      // ambient held within 0 to 40
      if (CAL_STEP_SELECTED_I && !cal_busy) begin
        if (UP_KEY_I && !up_prev_reg && (cal_ref_reg < CAL_AMB_MAX_C)) begin
          cal_ref_reg <= cal_ref_reg + 10'h001;
        end else if (DOWN_KEY_I && !down_prev_reg && (cal_ref_reg != 10'h000)) begin
          cal_ref_reg <= cal_ref_reg - 10'h001;
        end
      end
    end
  end

  // ==========================================================
  // Registered outputs
  // ==========================================================
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      set_cap_reg <= 10'h000;
      heat_en_reg <= 1'b0;
      alarm_reg <= 1'b0;
      level_reg <= 12'h000;
      hot_reg <= 1'b0;
      lock_h_reg <= 1'b0;
      lock_w_reg <= 1'b0;
      show_reg <= 1'b0;
    end else if (CE_I) begin
      set_cap_reg <= set_cap;
      heat_en_reg <= heat_next;
      alarm_reg <= alarm_next;
      level_reg <= level_next;
      hot_reg <= still_hot;
      lock_h_reg <= lock_h;
      lock_w_reg <= lock_w;
      // value and bar in home position
      show_reg <= HOME_POSITION_I;
    end
  end

  assign HEAT_ENABLE_O = heat_en_reg;
  assign TIMED_CYCLE_START_O = start_pulse_reg;
  assign SET_POINT_O = set_cap_reg;
  assign ALARM_O = alarm_reg;
  assign ANALOG_LEVEL_O = level_reg;
  assign CAL_BUSY_O = busy_reg;
  assign CAL_COUNT_O = count_reg;
  assign CAL_ERROR_O = cal_err_reg;
  assign CAL_REF_O = cal_ref_reg;
  assign MSG_STILL_HOT_O = hot_reg;
  assign MSG_LOCK_HEAT_O = lock_h_reg;
  assign MSG_LOCK_WARMUP_O = lock_w_reg;
  assign SHOW_VALUE_O = show_reg;
  assign SHOW_BAR_O = show_reg;
endmodule

// >>> test_heatseal_control_sequencer.sv
`timescale 1ns/1ps
module test_heatseal_control_sequencer
  import hscs_pkg::*;
;
  // ==========================================================
  // Stimulus and observed signals, named as the ports
  // ==========================================================
  logic CLK_I = 1'h0;
  logic RESET_N_I = 1'h0;
  logic CE_I = 1'h1;
  logic MANUAL_HEAT_KEY_I, HOME_POSITION_I, CAL_STEP_SELECTED_I, CONFIRM_KEY_I, UP_KEY_I;
  logic DOWN_KEY_I, TIME_CONTROL_I, OUT_REF_MODE_I, COOLING_FAST_I, BAND_VARIES_I;
  logic FAULT_ACTIVE_I, RAN_OK_I, TIMED_CYCLE_DONE_I;
  logic [1:0] RANGE_I;
  logic [TEMP_W-1:0] MAX_TEMP_I, SET_POINT_I, ACTUAL_TEMP_I, SET_POINT_O, CAL_REF_O;
  logic [CODE_W-1:0] FAULT_CODE_I;
  logic [DAC_W-1:0] FAULT_LEVEL_I, ANALOG_LEVEL_O;
  logic HEAT_ENABLE_O, TIMED_CYCLE_START_O, ALARM_O, CAL_BUSY_O, CAL_ERROR_O;
  logic MSG_STILL_HOT_O, MSG_LOCK_HEAT_O, MSG_LOCK_WARMUP_O, SHOW_VALUE_O, SHOW_BAR_O;
  logic [3:0] CAL_COUNT_O;
  wire logic HEAT_REQUEST_I, WARMUP_REQUEST_I;
  int n_fail = 0, cmp_count = 0, n_start = 0, n0;
  // Expected ceilings and levels; 200 shows on a 300 scale, 400 on 500
  logic [TEMP_W-1:0] ceil_tab [4] = '{CEIL_200, CEIL_300, CEIL_400, CEIL_500};
  logic [DAC_W-1:0] lvl100 [4] = '{12'h555, 12'h555, 12'h333, 12'h333};
  logic [DAC_W-1:0] lvl300 [4] = '{12'hFFF, 12'hFFF, 12'h999, 12'h999};
  logic [CODE_W-1:0] alarm_tab [6] = '{10'h068, 10'h069, 10'h06F, 10'h070, 10'h071, 10'h0D3};
  logic [CODE_W-1:0] block_tab [5] = '{10'h065, 10'h0C9, 10'h0CB, 10'h321, 10'h3B6};

  hscs_top DUT (.CLK_I, .RESET_N_I, .CE_I, .HEAT_REQUEST_I, .WARMUP_REQUEST_I,
    .MANUAL_HEAT_KEY_I, .HOME_POSITION_I, .CAL_STEP_SELECTED_I, .CONFIRM_KEY_I, .UP_KEY_I,
    .DOWN_KEY_I, .TIME_CONTROL_I, .OUT_REF_MODE_I, .RANGE_I, .MAX_TEMP_I, .SET_POINT_I,
    .ACTUAL_TEMP_I, .COOLING_FAST_I, .BAND_VARIES_I, .FAULT_ACTIVE_I, .FAULT_CODE_I,
    .FAULT_LEVEL_I, .RAN_OK_I, .TIMED_CYCLE_DONE_I, .HEAT_ENABLE_O, .TIMED_CYCLE_START_O,
    .SET_POINT_O, .ALARM_O, .ANALOG_LEVEL_O, .CAL_BUSY_O, .CAL_COUNT_O, .CAL_ERROR_O,
    .CAL_REF_O, .MSG_STILL_HOT_O, .MSG_LOCK_HEAT_O, .MSG_LOCK_WARMUP_O, .SHOW_VALUE_O,
    .SHOW_BAR_O);
  hscs_machine PART (.clk_i(CLK_I), .heat_o(HEAT_REQUEST_I), .warm_o(WARMUP_REQUEST_I));

  // ==========================================================
  // Clock, pulse counter and helpers
  // ==========================================================
  always #20 CLK_I = ~CLK_I;
  // Counted at the falling edge so a one-cycle pulse is seen once
  always @(negedge CLK_I) if (TIMED_CYCLE_START_O === 1'h1) n_start++;
  task automatic tick(input int n);
    repeat (n) @(negedge CLK_I);
  endtask
  task chk(input logic [11:0] g, input logic [11:0] e);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  task chkb(input logic g, input logic e);
    chk({11'h000, g}, {11'h000, e});
  endtask
  task press(input logic up);
    UP_KEY_I = up;
    DOWN_KEY_I = ~up;
    tick(1);
    {UP_KEY_I, DOWN_KEY_I} = 2'h0;
    tick(1);
  endtask
  // Confirm needs a fresh rising edge each time
  task confirm;
    CONFIRM_KEY_I = 1'h1;
    tick(1);
    CONFIRM_KEY_I = 1'h0;
    tick(2);
  endtask
  task results;
    if (n_fail == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Whole sequence is a few hundred cycles; this is ample
  initial begin
    tick(5000);
    n_fail++;
    results();
  end

  // ==========================================================
  // Scenarios
  // ==========================================================
  initial begin
    {MANUAL_HEAT_KEY_I, HOME_POSITION_I, CAL_STEP_SELECTED_I, CONFIRM_KEY_I, UP_KEY_I} = 5'h00;
    {DOWN_KEY_I, TIME_CONTROL_I, OUT_REF_MODE_I, COOLING_FAST_I, BAND_VARIES_I} = 5'h00;
    {FAULT_ACTIVE_I, TIMED_CYCLE_DONE_I, RAN_OK_I} = 3'h1;
    {RANGE_I, MAX_TEMP_I, SET_POINT_I, ACTUAL_TEMP_I} = {RANGE_500, 10'h3FF, 10'h064, 10'h000};
    {FAULT_CODE_I, FAULT_LEVEL_I} = 22'h000000;
    tick(20);
    RESET_N_I = 1'h1;
    tick(2);
    chk({2'h0, CAL_REF_O}, 12'h014);
    CAL_STEP_SELECTED_I = 1'h1;
    repeat (25) press(1'h1);
    chk({2'h0, CAL_REF_O}, 12'h028);
    repeat (45) press(1'h0);
    chk({2'h0, CAL_REF_O}, 12'h000);
    press(1'h1);
    chk({2'h0, CAL_REF_O}, 12'h001);
    CAL_STEP_SELECTED_I = 1'h0;
    SET_POINT_I = 10'h3FF;
    for (int r = 0; r < 4; r++) begin
      {RANGE_I, ACTUAL_TEMP_I} = {2'(r), 10'h064};
      tick(3);
      chk({2'h0, SET_POINT_O}, {2'h0, ceil_tab[r]});
      chk(ANALOG_LEVEL_O, lvl100[r]);
      ACTUAL_TEMP_I = 10'h12C;
      tick(3);
      chk(ANALOG_LEVEL_O, lvl300[r]);
    end
    ACTUAL_TEMP_I = 10'h000;
    MAX_TEMP_I = 10'h096;
    tick(3);
    chk(ANALOG_LEVEL_O, 12'h000);
    chk({2'h0, SET_POINT_O}, 12'h096);
    // Clock enable low must freeze the capped set point
    CE_I = 1'h0;
    MAX_TEMP_I = 10'h0C8;
    tick(3);
    chk({2'h0, SET_POINT_O}, 12'h096);
    CE_I = 1'h1;
    tick(2);
    chk({2'h0, SET_POINT_O}, 12'h0C8);
    {MAX_TEMP_I, SET_POINT_I, OUT_REF_MODE_I} = {10'h3FF, 10'h064, 1'h1};
    tick(3);
    chk(ANALOG_LEVEL_O, 12'hFFF);
    {FAULT_ACTIVE_I, FAULT_CODE_I, FAULT_LEVEL_I} = {1'h1, 10'h12C, 12'h5A5};
    tick(3);
    chk(ANALOG_LEVEL_O, 12'h5A5);
    {FAULT_ACTIVE_I, OUT_REF_MODE_I, SET_POINT_I} = {2'h0, 10'h028};
    PART.heat(1'h1);
    tick(5);
    chkb(HEAT_ENABLE_O, 1'h0);
    SET_POINT_I = 10'h029;
    tick(5);
    chkb(HEAT_ENABLE_O, 1'h1);
    PART.heat(1'h0);
    tick(5);
    chkb(HEAT_ENABLE_O, 1'h0);
    {HOME_POSITION_I, TIME_CONTROL_I, MANUAL_HEAT_KEY_I} = 3'h7;
    n0 = n_start;
    tick(3);
    chkb(HEAT_ENABLE_O, 1'h1);
    chkb(SHOW_VALUE_O & SHOW_BAR_O, 1'h1);
    SET_POINT_I = 10'h028;
    tick(3);
    chkb(HEAT_ENABLE_O, 1'h0);
    {SET_POINT_I, HOME_POSITION_I} = {10'h064, 1'h0};
    tick(3);
    chkb(HEAT_ENABLE_O, 1'h0);
    chk(12'(n_start - n0), 12'h000);
    MANUAL_HEAT_KEY_I = 1'h0;
    repeat (2) begin
      PART.cycle(20);
      TIMED_CYCLE_DONE_I = 1'h1;
      tick(1);
      TIMED_CYCLE_DONE_I = 1'h0;
    end
    chk(12'(n_start - n0), 12'h002);
    TIME_CONTROL_I = 1'h0;
    FAULT_ACTIVE_I = 1'h1;
    foreach (alarm_tab[i]) begin
      FAULT_CODE_I = alarm_tab[i];
      PART.heat(1'h1);
      tick(5);
      chkb(ALARM_O & ~HEAT_ENABLE_O, 1'h1);
      PART.heat(1'h0);
      tick(5);
    end
    {FAULT_ACTIVE_I, CAL_STEP_SELECTED_I} = 2'h1;
    PART.heat(1'h1);
    tick(5);
    confirm();
    chkb(MSG_LOCK_HEAT_O & ~CAL_BUSY_O, 1'h1);
    PART.heat(1'h0);
    PART.warm(1'h1);
    tick(5);
    confirm();
    chkb(MSG_LOCK_WARMUP_O & ~CAL_BUSY_O, 1'h1);
    PART.warm(1'h0);
    COOLING_FAST_I = 1'h1;
    tick(5);
    confirm();
    chkb(MSG_STILL_HOT_O & ~CAL_BUSY_O, 1'h1);
    {COOLING_FAST_I, FAULT_ACTIVE_I} = 2'h1;
    foreach (block_tab[i]) begin
      {FAULT_CODE_I, RAN_OK_I} = {block_tab[i], (i != 0)};
      tick(2);
      confirm();
      chkb(CAL_BUSY_O, 1'h0);
    end
    {FAULT_CODE_I, RAN_OK_I} = {10'h065, 1'h1};
    tick(2);
    confirm();
    chkb(CAL_BUSY_O, 1'h1);
    chk(ANALOG_LEVEL_O, 12'h000);
    chk({8'h00, CAL_COUNT_O}, 12'h00D);
    BAND_VARIES_I = 1'h1;
    PART.heat(1'h1);
    tick(5);
    chkb(HEAT_ENABLE_O, 1'h0);
    chkb(CAL_BUSY_O & ~CAL_ERROR_O, 1'h1);
    PART.heat(1'h0);
    RESET_N_I = 1'h0;
    tick(20);
    RESET_N_I = 1'h1;
    tick(2);
    chk({1'h0, CAL_BUSY_O, CAL_REF_O}, 12'h014);
    results();
  end
endmodule
